/* rtl/gpa_pkg.sv */
/*
  gpa_pkg: shared constants and carrier types for the two-port gpio block
  with alternate functions.
  assumes a byte-wide register port clocked by the cpu clock.
*/
package gpa_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] OFS_A_LATCH = 8'h00;
  localparam logic [7:0] OFS_A_DIR   = 8'h01;
  localparam logic [7:0] OFS_B_LATCH = 8'h02;
  localparam logic [7:0] OFS_B_DIR   = 8'h03;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h08;
  localparam logic [7:0] OFS_MISC    = 8'h09;

  // values after reset
  localparam logic [7:0] RST_LATCH  = 8'h00;
  localparam logic [7:0] RST_DIR    = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_MISC   = 8'hf0;

  // misc control fields; the upper nibble is reserved and reads as ones
  localparam int         MISC_CLK_OUT  = 0;
  localparam int         MISC_USB_OE   = 1;
  localparam int         MISC_CLKDIV   = 2;
  localparam int         MISC_LVD_OFF  = 3;
  localparam logic [3:0] MISC_RSVD_VAL = 4'hf;

  // edge sense per irq line, bit k is line k+1: lines 1,2,5,6 rising
  localparam logic [7:0] IRQ_RISE_MASK = 8'h33;

  // pins of port a that carry a pull-up while they are inputs
  localparam logic [7:0] A_PULLUP_MASK = 8'hf9;

  // fixed pin positions on port a
  localparam int A_CLK_PIN  = 0;
  localparam int A_SDA_PIN  = 1;
  localparam int A_SCL_PIN  = 2;
  localparam int A_ECLK_PIN = 3;
  localparam int A_CAP1_PIN = 4;
  localparam int A_CAP2_PIN = 5;
  localparam int A_CMP1_PIN = 6;
  localparam int A_CMP2_PIN = 7;

  // input synchroniser length
  localparam int SYNC_STAGES = 3;

  // one register access from the cpu side
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gpa_reg_req_t;

  // peripheral signals that steer port a pins
  typedef struct packed {
    logic i2c_enable;
    logic sda_drive_low;
    logic scl_drive_low;
    logic timer_clock_sel_hi;
    logic timer_clock_sel_lo;
    logic compare_out_one_enable;
    logic compare_out_two_enable;
    logic timer_compare_out_one;
    logic timer_compare_out_two;
  } gpa_periph_t;

endpackage

/* rtl/gpa_ports.sv */
/*
  gpa_ports: ports a and b of eight pins each, their latch and direction
  registers, edge interrupt lines, and pin hookup of timer, i2c, clock out
  and analog channel select.
  assumes pin inputs are asynchronous, peripheral signals come from logic
  on clk, and the surroundings resolve each pin from its out/oe pair.
*/
// How it works
// - each port has eight pins, each input or output on its own
// - bit x of latch and direction registers steers pin x
// - direction bit 0 means input, 1 means output
// - reading latch of an input bit gives the synchronised pin level
// - output bits drive the latch value and read back the latch
// - a pin in output mode never raises an edge request
// - enabled input pins raise a request on their own edge sense
// - all pin requests are ORed onto one external request line
// - an active peripheral output overrides latch and direction on its pin
// - peripheral outputs force output mode, push-pull or open drain
// - pins feeding peripherals stay readable through the latch register
// - port a bit 0 outputs half the cpu clock when clock-out is selected
// - port a 4..7 reset pulled-up inputs, capture inputs, compare outputs
// - port a 1,2 unpulled inputs, open drain outputs, i2c data and clock
// - port b resets unpulled; pin n routed to converter when channel is n
// - port b 4..7 are irq lines 5..8, each with its own enable bit
// - lines 1,2,5,6 rising, 3,4,7,8 falling, one enable bit each
// - irq enable register is read/write and resets to zero
`timescale 1ns/100ps

module gpa_ports
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire gpa_pkg::gpa_reg_req_t bus_req,
  output logic [7:0]                bus_rdata,
  input  wire logic [7:0]           pa_in,
  output logic [7:0]                pa_out,
  output logic [7:0]                pa_oe,
  output logic [7:0]                pa_pullup,
  input  wire logic [7:0]           pb_in,
  output logic [7:0]                pb_out,
  output logic [7:0]                pb_oe,
  input  wire gpa_pkg::gpa_periph_t periph,
  input  wire logic                 adc_enable,
  input  wire logic [2:0]           analog_channel_sel,
  output logic [7:0]                analog_route,
  output logic                      timer_capture_in_one,
  output logic                      timer_capture_in_two,
  output logic                      timer_external_clock,
  output logic                      sda_in,
  output logic                      scl_in,
  output logic                      clock_out_select,
  output logic [7:0]                ext_irq_lines,
  output logic                      ext_irq_req
);

  // register state
  logic [7:0] a_latch_reg;
  logic [7:0] a_dir_reg;
  logic [7:0] b_latch_reg;
  logic [7:0] b_dir_reg;
  logic [7:0] irq_en_reg;
  logic [3:0] misc_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // synchroniser chains and filtered levels
  logic [7:0] a_s1_reg;
  logic [7:0] a_s2_reg;
  logic [7:0] a_s3_reg;
  logic [7:0] b_s1_reg;
  logic [7:0] b_s2_reg;
  logic [7:0] b_s3_reg;
  logic [7:0] a_lvl_reg;
  logic [7:0] b_lvl_reg;
  logic [7:0] a_prev_reg;
  logic [7:0] b_prev_reg;

  // pin drive and irq state
  logic [7:0] a_out_reg;
  logic [7:0] a_oe_reg;
  logic [7:0] a_pu_reg;
  logic [7:0] b_out_reg;
  logic [7:0] b_oe_reg;
  logic [7:0] a_out_next;
  logic [7:0] a_oe_next;
  logic       clk_half_reg;
  logic [7:0] route_reg;
  logic [7:0] irq_pulse_reg;
  logic       irq_req_reg;
  logic [7:0] irq_pin_lvl;
  logic [7:0] irq_pin_prev;
  logic [7:0] irq_pin_in;
  logic [7:0] irq_next;
  logic [4:0] periph_sync_reg;

  // per bit: output bits return the latch, input bits the pin level
  function automatic logic [7:0] port_read(input logic [7:0] dir, latch, lvl);
    port_read = (dir & latch) | (~dir & lvl);
  endfunction

  // a new level counts only once stages two and three agree
  function automatic logic [7:0] settle(input logic [7:0] s2, s3, lvl);
    settle = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & lvl);
  endfunction

  // pin synchronisers; stage one feeds stage two only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      a_s1_reg <= gpa_pkg::A_PULLUP_MASK; // pulled-up pins idle high: no false edge
      a_s2_reg <= gpa_pkg::A_PULLUP_MASK;
      a_s3_reg <= gpa_pkg::A_PULLUP_MASK;
      b_s1_reg <= 8'h00;
      b_s2_reg <= 8'h00;
      b_s3_reg <= 8'h00;
      a_lvl_reg <= gpa_pkg::A_PULLUP_MASK;
      b_lvl_reg <= 8'h00;
      a_prev_reg <= gpa_pkg::A_PULLUP_MASK;
      b_prev_reg <= 8'h00;
    end
    else
    begin
      a_s1_reg <= pa_in;
      a_s2_reg <= a_s1_reg;
      a_s3_reg <= a_s2_reg;
      b_s1_reg <= pb_in;
      b_s2_reg <= b_s1_reg;
      b_s3_reg <= b_s2_reg;
      a_lvl_reg <= settle(a_s2_reg, a_s3_reg, a_lvl_reg);
      b_lvl_reg <= settle(b_s2_reg, b_s3_reg, b_lvl_reg);
      a_prev_reg <= a_lvl_reg;
      b_prev_reg <= b_lvl_reg;
    end
  end

  // register writes; writes to the latch land even on input bits
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      a_latch_reg <= gpa_pkg::RST_LATCH;
      a_dir_reg   <= gpa_pkg::RST_DIR;
      b_latch_reg <= gpa_pkg::RST_LATCH;
      b_dir_reg   <= gpa_pkg::RST_DIR;
      irq_en_reg  <= gpa_pkg::RST_IRQ_EN;
      misc_reg    <= gpa_pkg::RST_MISC[3:0];
    end
    else if (bus_req.wr)
    begin
      case (bus_req.addr)
        gpa_pkg::OFS_A_LATCH: a_latch_reg <= bus_req.wdata;
        gpa_pkg::OFS_A_DIR:   a_dir_reg   <= bus_req.wdata;
        gpa_pkg::OFS_B_LATCH: b_latch_reg <= bus_req.wdata;
        gpa_pkg::OFS_B_DIR:   b_dir_reg   <= bus_req.wdata;
        gpa_pkg::OFS_IRQ_EN:  irq_en_reg  <= bus_req.wdata;
        gpa_pkg::OFS_MISC:
        begin
          // lvd-off and clkdiv are set-only until the next reset
          misc_reg[3:2] <= misc_reg[3:2] | bus_req.wdata[3:2];
          misc_reg[1:0] <= bus_req.wdata[1:0];
        end
        default: ;
      endcase
    end
  end

  // read decode; unmapped offsets return zero
  always_comb
  begin
    rdata_next = 8'h00;
    case (bus_req.addr)
      gpa_pkg::OFS_A_LATCH: rdata_next = port_read(a_dir_reg, a_latch_reg, a_lvl_reg);
      gpa_pkg::OFS_A_DIR:   rdata_next = a_dir_reg;
      gpa_pkg::OFS_B_LATCH: rdata_next = port_read(b_dir_reg, b_latch_reg, b_lvl_reg);
      gpa_pkg::OFS_B_DIR:   rdata_next = b_dir_reg;
      gpa_pkg::OFS_IRQ_EN:  rdata_next = irq_en_reg;
      gpa_pkg::OFS_MISC:    rdata_next = {gpa_pkg::MISC_RSVD_VAL, misc_reg};
      default:              rdata_next = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst || !bus_req.rd)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // port a drive: alternate functions win over latch and direction
  always_comb
  begin
    a_out_next = a_latch_reg;
    a_oe_next  = a_dir_reg;
    if (misc_reg[gpa_pkg::MISC_CLK_OUT])
    begin
      a_out_next[gpa_pkg::A_CLK_PIN] = clk_half_reg;
      a_oe_next[gpa_pkg::A_CLK_PIN]  = 1'b1;
    end
    // sda and scl only ever pull low, whoever drives them
    a_out_next[gpa_pkg::A_SDA_PIN] = 1'b0;
    a_out_next[gpa_pkg::A_SCL_PIN] = 1'b0;
    if (periph.i2c_enable)
    begin
      a_oe_next[gpa_pkg::A_SDA_PIN] = periph.sda_drive_low;
      a_oe_next[gpa_pkg::A_SCL_PIN] = periph.scl_drive_low;
    end
    else
    begin
      a_oe_next[gpa_pkg::A_SDA_PIN] = a_dir_reg[1] & ~a_latch_reg[1];
      a_oe_next[gpa_pkg::A_SCL_PIN] = a_dir_reg[2] & ~a_latch_reg[2];
    end
    if (periph.compare_out_one_enable)
    begin
      a_out_next[gpa_pkg::A_CMP1_PIN] = periph.timer_compare_out_one;
      a_oe_next[gpa_pkg::A_CMP1_PIN]  = 1'b1;
    end
    if (periph.compare_out_two_enable)
    begin
      a_out_next[gpa_pkg::A_CMP2_PIN] = periph.timer_compare_out_two;
      a_oe_next[gpa_pkg::A_CMP2_PIN]  = 1'b1;
    end
  end

  // pin drivers; the clock out is clk/2 since outputs come from flip-flops
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_half_reg <= 1'b0;
      a_out_reg <= 8'h00;
      a_oe_reg  <= 8'h00;
      a_pu_reg  <= gpa_pkg::A_PULLUP_MASK;
      b_out_reg <= 8'h00;
      b_oe_reg  <= 8'h00;
    end
    else
    begin
      clk_half_reg <= ~clk_half_reg;
      a_out_reg <= a_out_next;
      a_oe_reg  <= a_oe_next;
      a_pu_reg  <= ~a_oe_next & gpa_pkg::A_PULLUP_MASK;
      b_out_reg <= b_latch_reg;
      b_oe_reg  <= b_dir_reg;
    end
  end

  // peripheral inputs read the synchronised pin levels
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      periph_sync_reg <= 5'h00;
      route_reg <= 8'h00;
    end
    else
    begin
      periph_sync_reg[0] <= a_lvl_reg[gpa_pkg::A_CAP1_PIN];
      periph_sync_reg[1] <= a_lvl_reg[gpa_pkg::A_CAP2_PIN];
      periph_sync_reg[2] <= periph.timer_clock_sel_hi & periph.timer_clock_sel_lo
                            & a_lvl_reg[gpa_pkg::A_ECLK_PIN];
      periph_sync_reg[3] <= a_lvl_reg[gpa_pkg::A_SDA_PIN];
      periph_sync_reg[4] <= a_lvl_reg[gpa_pkg::A_SCL_PIN];
      route_reg <= adc_enable ? (8'h01 << analog_channel_sel) : 8'h00;
    end
  end

  // irq sources: port a 4..7 are lines 1..4, port b 4..7 are lines 5..8
  assign irq_pin_lvl  = {b_lvl_reg[7:4], a_lvl_reg[7:4]};
  assign irq_pin_prev = {b_prev_reg[7:4], a_prev_reg[7:4]};
  // a compare output in use counts as output mode for its pin
  assign irq_pin_in   = ~{b_dir_reg[7:4], a_dir_reg[7] | periph.compare_out_two_enable,
                          a_dir_reg[6] | periph.compare_out_one_enable, a_dir_reg[5:4]};
  assign irq_next = irq_en_reg & irq_pin_in
                    & ((gpa_pkg::IRQ_RISE_MASK & irq_pin_lvl & ~irq_pin_prev)
                    | (~gpa_pkg::IRQ_RISE_MASK & ~irq_pin_lvl & irq_pin_prev));

  // one-cycle request pulses, ORed onto the shared request line
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_pulse_reg <= 8'h00;
      irq_req_reg   <= 1'b0;
    end
    else
    begin
      irq_pulse_reg <= irq_next;
      irq_req_reg   <= |irq_next;
    end
  end

  assign bus_rdata            = rdata_reg;
  assign pa_out               = a_out_reg;
  assign pa_oe                = a_oe_reg;
  assign pa_pullup            = a_pu_reg;
  assign pb_out               = b_out_reg;
  assign pb_oe                = b_oe_reg;
  assign analog_route         = route_reg;
  assign timer_capture_in_one = periph_sync_reg[0];
  assign timer_capture_in_two = periph_sync_reg[1];
  assign timer_external_clock = periph_sync_reg[2];
  assign sda_in               = periph_sync_reg[3];
  assign scl_in               = periph_sync_reg[4];
  assign clock_out_select     = misc_reg[gpa_pkg::MISC_CLK_OUT];
  assign ext_irq_lines        = irq_pulse_reg;
  assign ext_irq_req          = irq_req_reg;

  // checks
  chk_dir_drive: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> pa_oe[3] == $past(a_dir_reg[3]))
    else $error("pa3 enable does not follow its direction bit");
  chk_read_input: assert property (@(posedge clk) disable iff (rst)
    bus_req.rd && bus_req.addr == gpa_pkg::OFS_A_LATCH && a_dir_reg == 8'h00
    |=> bus_rdata == $past(a_lvl_reg))
    else $error("input read does not return the pin level");
  chk_read_latch: assert property (@(posedge clk) disable iff (rst)
    bus_req.rd && bus_req.addr == gpa_pkg::OFS_B_LATCH && b_dir_reg == 8'hff
    |=> bus_rdata == $past(b_latch_reg))
    else $error("output read does not return the latch");
  chk_out_noirq: assert property (@(posedge clk) disable iff (rst)
    b_dir_reg[4] |=> !ext_irq_lines[4])
    else $error("output pin raised an edge request");
  chk_irq_or: assert property (@(posedge clk) disable iff (rst)
    ext_irq_req == (|ext_irq_lines))
    else $error("shared request is not the OR of the lines");
  chk_rise_edge: assert property (@(posedge clk) disable iff (rst)
    irq_en_reg[0] && !a_dir_reg[4] && a_lvl_reg[4] && !a_prev_reg[4]
    |=> ext_irq_lines[0] ##1 !ext_irq_lines[0])
    else $error("rising edge on line one missed or stretched");
  chk_fall_edge: assert property (@(posedge clk) disable iff (rst)
    $past(a_lvl_reg[6]) && !a_lvl_reg[6] && !irq_en_reg[2] |=> !ext_irq_lines[2])
    else $error("disabled line three raised a request");
  chk_clk_out: assert property (@(posedge clk) disable iff (rst)
    misc_reg[gpa_pkg::MISC_CLK_OUT] ##1 misc_reg[gpa_pkg::MISC_CLK_OUT]
    |=> pa_oe[0] && pa_out[0] != $past(pa_out[0]))
    else $error("clock out pin not toggling");
  chk_open_drain: assert property (@(posedge clk) disable iff (rst)
    pa_out[2:1] == 2'b00)
    else $error("i2c pin driven high");
  chk_cmp_prio: assert property (@(posedge clk) disable iff (rst)
    periph.compare_out_one_enable
    |=> pa_oe[6] && pa_out[6] == $past(periph.timer_compare_out_one))
    else $error("compare output did not take pa6");
  chk_adc_route: assert property (@(posedge clk) disable iff (rst)
    adc_enable |=> analog_route == (8'h01 << $past(analog_channel_sel)))
    else $error("analog route does not match channel");
  chk_sync_lag: assert property (@(posedge clk) disable iff (rst)
    $past(rst) == 1'b0 && a_s2_reg == a_s3_reg |=> a_lvl_reg == $past(a_s3_reg))
    else $error("settled level not taken");

  cov_irq: cover property (@(posedge clk) disable iff (rst) ext_irq_req);
  cov_read_in: cover property (@(posedge clk) disable iff (rst)
    bus_req.rd && bus_req.addr == gpa_pkg::OFS_A_LATCH && a_dir_reg == 8'h00);
  cov_clk_out: cover property (@(posedge clk) disable iff (rst) pa_oe[0] && pa_out[0]);
  cov_i2c: cover property (@(posedge clk) disable iff (rst) periph.i2c_enable && pa_oe[1]);

endmodule

/* verif/gpa_pin_model.sv */
/*
  gpa_pin_model: pad-side model of the pins of ports a and b.
  assumes the bench says which pins it holds from outside and at what level.
*/
`timescale 1ns/100ps

module gpa_pin_model
(
  input  wire logic       clk,
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pa_pullup,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe,
  input  wire logic [7:0] ext_a,
  input  wire logic [7:0] ext_a_en,
  input  wire logic [7:0] ext_b,
  input  wire logic [7:0] ext_b_en,
  output logic [7:0]      pa_in,
  output logic [7:0]      pb_in
);

  logic [7:0] float_pat = 8'h55;

  // a pin nobody holds wanders, so a stale level can never pass for a read
  always @(posedge clk)
    float_pat <= ~float_pat;

  // device drive wins, then the outside driver, then the pull-up, else it floats
  always_comb
  begin
    pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a_en & ext_a)
          | (~pa_oe & ~ext_a_en & (pa_pullup | float_pat));
    pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b_en & ext_b) | (~pb_oe & ~ext_b_en & float_pat);
  end

endmodule

/* verif/gpa_ports_tb_top.sv */
/*
  gpa_ports_tb_top: self-checking bench for the two-port gpio block.
  assumes the pin model on the pad side and all stimulus launched on clk.
*/
`timescale 1ns/100ps

module gpa_ports_tb_top;

  localparam logic [7:0] RA [5] = '{gpa_pkg::OFS_A_DIR, gpa_pkg::OFS_B_DIR,
                                    gpa_pkg::OFS_IRQ_EN, gpa_pkg::OFS_MISC, 8'h05};
  localparam logic [7:0] RV [5] = '{gpa_pkg::RST_DIR, gpa_pkg::RST_DIR,
                                    gpa_pkg::RST_IRQ_EN, gpa_pkg::RST_MISC, 8'h00};
  localparam logic [7:0] IDLE_A = {~gpa_pkg::IRQ_RISE_MASK[3:0], 4'h0};
  localparam logic [7:0] IDLE_B = {~gpa_pkg::IRQ_RISE_MASK[7:4], 4'h0};

  logic                  clk;
  logic                  rst;
  gpa_pkg::gpa_reg_req_t req;
  gpa_pkg::gpa_periph_t  periph;
  logic [7:0]            rdata, pa_in, pa_out, pa_oe, pa_pu, pb_in, pb_out, pb_oe;
  logic [7:0]            route, irq_lines, ext_a, ext_b, ext_a_en, ext_b_en;
  logic [2:0]            chan;
  logic                  adc_en, cap1, cap2, eclk, sda, scl, clk_sel, irq_req;
  int                    n_fail;
  int                    tests_run;

  gpa_ports i_gpa_ports (.clk(clk), .rst(rst), .bus_req(req), .bus_rdata(rdata),
    .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pu), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe(pb_oe), .periph(periph), .adc_enable(adc_en),
    .analog_channel_sel(chan), .analog_route(route), .timer_capture_in_one(cap1),
    .timer_capture_in_two(cap2), .timer_external_clock(eclk), .sda_in(sda), .scl_in(scl),
    .clock_out_select(clk_sel), .ext_irq_lines(irq_lines), .ext_irq_req(irq_req));

  gpa_pin_model i_gpa_pin_model (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pullup(pa_pu), .pb_out(pb_out), .pb_oe(pb_oe), .ext_a(ext_a), .ext_a_en(ext_a_en),
    .ext_b(ext_b), .ext_b_en(ext_b_en), .pa_in(pa_in), .pb_in(pb_in));

  // free-running cpu clock, 8 ns period
  always #4 clk = ~clk;

  // output bits read back the latch, input bits the pin
  function automatic logic [7:0] latch_read(input logic [7:0] dir, lat, pin);
    return (dir & lat) | (~dir & pin);
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one write strobe, then an idle cycle so no signal is driven twice at one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    chk(what, exp, rdata);
  endtask

  // mode 0 enabled input, 1 only other lines enabled, 2 pin driven as output
  task automatic irq_case(input int k, input int m);
    logic [7:0] seen, bm, idle, lo, dof;
    logic       bad;
    seen = 8'h00;
    bad  = 1'b0;
    bm   = 8'h10 << (k % 4);
    idle = (k < 4) ? IDLE_A : IDLE_B;
    lo   = (k < 4) ? gpa_pkg::OFS_A_LATCH : gpa_pkg::OFS_B_LATCH;
    dof  = (k < 4) ? gpa_pkg::OFS_A_DIR : gpa_pkg::OFS_B_DIR;
    wr(lo, idle);
    wr(dof, (m == 2) ? bm : 8'h00);
    tick(8);
    wr(gpa_pkg::OFS_IRQ_EN, (m == 1) ? ~(8'h01 << k) : (8'h01 << k));
    if (m == 2)
      wr(lo, idle ^ bm);
    else if (k < 4)
      ext_a <= IDLE_A ^ bm;
    else
      ext_b <= IDLE_B ^ bm;
    repeat (12)
    begin
      @(posedge clk);
      seen = seen | irq_lines;
      bad  = bad | (irq_req !== (|irq_lines));
    end
    chk("irq lines", (m == 0) ? (8'h01 << k) : 8'h00, seen);
    chk("irq req vs lines", 8'h00, {7'h0, bad});
    wr(gpa_pkg::OFS_IRQ_EN, 8'h00);
    ext_a <= IDLE_A;
    ext_b <= IDLE_B;
    wr(dof, 8'h00);
    tick(8);
  endtask

  // watchdog: the whole run needs about eleven hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    logic [7:0] v, d, e;
    clk = 1'b0;
    rst = 1'b1;
    req = '0;
    periph = '0;
    adc_en = 1'b0;
    chan = 3'h0;
    ext_a = 8'h00;
    ext_b = 8'h00;
    ext_a_en = 8'hff;
    ext_b_en = 8'hff;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(9067));
    tick(3);
    rst <= 1'b0;
    tick(2);
    chk("reset pull-ups", gpa_pkg::A_PULLUP_MASK, pa_pu);
    for (int i = 0; i < 5; i++)
      rchk("reset value", RA[i], RV[i]);
    rchk("port b latch at reset", gpa_pkg::OFS_B_LATCH, 8'h00);
    // random latch and direction on port b, latch written first; first pass all outputs
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      d = (i == 0) ? 8'hff : 8'($urandom);
      e = 8'($urandom);
      wr(gpa_pkg::OFS_B_LATCH, v);
      wr(gpa_pkg::OFS_B_DIR, d);
      ext_b <= e;
      tick(8);
      chk("pb_out", v, pb_out);
      chk("pb_oe", d, pb_oe);
      rchk("b latch read", gpa_pkg::OFS_B_LATCH, latch_read(d, v, e));
    end
    // port a push-pull and open-drain outputs side by side
    wr(gpa_pkg::OFS_A_LATCH, 8'h81);
    wr(gpa_pkg::OFS_A_DIR, 8'h87);
    tick(4);
    chk("pa_oe mixed", 8'h87, pa_oe);
    chk("pa_out mixed", 8'h81, pa_out);
    chk("pull-ups while driven", 8'h78, pa_pu);
    rchk("a latch read", gpa_pkg::OFS_A_LATCH, 8'h81);
    wr(gpa_pkg::OFS_A_DIR, 8'h00);
    // clock out on pin 0 and set-only misc bits
    wr(gpa_pkg::OFS_MISC, 8'h01);
    tick(3);
    v = pa_out;
    @(posedge clk);
    chk("clock out toggles", {7'h0, ~v[0]}, {7'h0, pa_out[0]});
    chk("clock out select", 8'h01, {7'h0, clk_sel});
    chk("clock out drives", 8'h01, {7'h0, pa_oe[0]});
    wr(gpa_pkg::OFS_MISC, 8'h0c);
    wr(gpa_pkg::OFS_MISC, 8'h00);
    rchk("misc read", gpa_pkg::OFS_MISC, 8'hfc);
    chk("clock out off", 8'h00, {7'h0, clk_sel});
    // compare outputs take the pins although direction stays input
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      periph <= '{compare_out_one_enable: 1'b1, compare_out_two_enable: 1'b1,
                  timer_compare_out_one: v[0], timer_compare_out_two: v[1],
                  default: 1'b0};
      tick(3);
      chk("compare oe", 8'h03, {6'h0, pa_oe[7:6]});
      chk("compare out", {6'h0, v[1:0]}, {6'h0, pa_out[7:6]});
    end
    // capture and external clock inputs, pull-ups on released pins
    v = 8'($urandom);
    ext_a <= v;
    periph <= '{timer_clock_sel_hi: 1'b1, timer_clock_sel_lo: 1'b1, default: 1'b0};
    tick(8);
    chk("capture and ext clock", {5'h0, v[5:3]}, {5'h0, cap2, cap1, eclk});
    rchk("a pins read", gpa_pkg::OFS_A_LATCH, v);
    ext_a_en <= 8'h0f;
    tick(8);
    rchk("a pulled-up pins", gpa_pkg::OFS_A_LATCH, {4'hf, v[3:0]});
    ext_a_en <= 8'hff;
    ext_a <= 8'h06;
    // i2c data pulled low by the peripheral, clock released
    periph <= '{i2c_enable: 1'b1, sda_drive_low: 1'b1, default: 1'b0};
    tick(8);
    chk("i2c oe", 8'h01, {6'h0, pa_oe[2:1]});
    chk("i2c out", 8'h00, {6'h0, pa_out[2:1]});
    chk("i2c in", 8'h02, {6'h0, scl, sda});
    periph <= '0;
    // converter channel routing, pins held steady, interrupts off
    adc_en <= 1'b1;
    for (int n = 0; n < 8; n++)
    begin
      chan <= 3'(n);
      tick(2);
      chk("analog route", 8'h01 << n, route);
    end
    adc_en <= 1'b0;
    tick(2);
    chk("analog route off", 8'h00, route);
    // every irq line in every mode
    ext_a <= IDLE_A;
    ext_b <= IDLE_B;
    tick(8);
    for (int k = 0; k < 8; k++)
      for (int m = 0; m < 3; m++)
        irq_case(k, m);
    give_verdict();
  end

endmodule
